// [tetm_pkg.sv]
// shared constants and types for the thermal event timer monitor
package tetm_pkg;

   localparam int TETM_AW = 12;
   localparam int TETM_DW = 32;

   // register indices; the byte address is four times the index
   localparam logic [7:0] TETM_IDX_STATUS_TWO = 8'h42;
   localparam logic [7:0] TETM_IDX_MASK_ONE = 8'h74;
   localparam logic [7:0] TETM_IDX_MASK_TWO = 8'h75;
   localparam logic [7:0] TETM_IDX_CONFIG_THREE = 8'h78;
   localparam logic [7:0] TETM_IDX_TIMER_VALUE = 8'h79;
   localparam logic [7:0] TETM_IDX_TIMER_LIMIT = 8'h7a;
   localparam logic [7:0] TETM_IDX_CONFIG_FOUR = 8'h7d;

   // field positions
   localparam int TETM_CFG3_EVENT_EN = 1;
   localparam int TETM_CFG3_FULL_SPEED = 2;
   localparam int TETM_CFG4_FUNC_LO = 0;
   localparam int TETM_STAT2_FAN4_TIMER = 5;
   localparam int TETM_MASK1_DEDICATED = 0;
   localparam int TETM_MASK2_SHARED = 5;

   localparam logic [7:0] TETM_RESET_BYTE = 8'h00;
   localparam logic [7:0] TETM_DUTY_OFF = 8'h00;
   localparam logic [7:0] TETM_TIMER_FULL = 8'hff;

   localparam int TETM_NUM_FANS = 3;

   // timer resolution
   localparam longint TETM_CLK_PERIOD_PS = 40000;
   localparam longint TETM_TIMER_LSB_PS = 64'd22760000000;
   localparam int TETM_TIMER_LSB_CYCLES = int'(TETM_TIMER_LSB_PS / TETM_CLK_PERIOD_PS);
   localparam int TETM_PRESC_W = 20;

   typedef enum logic [1:0] {
      TETM_FUNC_FAN_TACH,
      TETM_FUNC_EVENT,
      TETM_FUNC_ALERT,
      TETM_FUNC_GP_IO
   } tetm_pin_func_type;

   typedef enum logic [1:0] {
      TETM_BUS_IDLE,
      TETM_BUS_ANSWER
   } tetm_bus_state_type;

   // fan state presented by the fan control logic
   typedef struct packed {
      logic manual_mode;
      logic [7:0] manual_duty;
      logic above_start_temp;
   } tetm_fan_type;

   function automatic logic [TETM_AW-1:0] tetm_byte_addr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

endpackage

// [tetm_sync.sv]
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module tetm_sync #(
   parameter int WIDTH = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage_one_reg;

   // reset to all ones: the event pins are active low, so idle is high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_one_reg <= '1;
         sync_out <= '1;
      end else begin
         stage_one_reg <= async_in;
         sync_out <= stage_one_reg;
      end
   end
endmodule // tetm_sync
`default_nettype wire

// [tetm_timer.sv]
// accumulating assertion timer with saturation and clear on read
`timescale 1ns/1ps
`default_nettype none
module tetm_timer
   import tetm_pkg::*;
#(
   parameter int LSB_CYCLES = TETM_TIMER_LSB_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic event_active,
   input wire logic clear,
   output logic [7:0] value
);
   logic [TETM_PRESC_W-1:0] presc_reg;
   logic [7:0] units_reg;
   logic seen_reg;
   wire tick = event_active && (presc_reg == TETM_PRESC_W'(LSB_CYCLES - 1));
   wire full = (units_reg == TETM_TIMER_FULL);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_reg <= '0;
         units_reg <= TETM_RESET_BYTE;
         seen_reg <= 1'b0;
      end else if (clear) begin
         presc_reg <= '0;
         units_reg <= TETM_RESET_BYTE;
         seen_reg <= event_active;
      end else begin
         if (event_active && !full)
            presc_reg <= tick ? '0 : presc_reg + 1'b1;
         if (tick && !full)
            units_reg <= units_reg + 8'h01;
         if (event_active)
            seen_reg <= 1'b1;
      end
   end

   // first assertion shows as 1 until two lsb periods have elapsed
   assign value = (units_reg >= 8'h02) ? units_reg : {7'b0, seen_reg};
endmodule // tetm_timer
`default_nettype wire

// [tetm_top.sv]
// thermal event timer monitor: pin function, fan full_speed_on_event, timer, limit and alert
// What this block does
// - shared pin function from two-bit select field
// - event disabled when enable bit clear
// - full speed fans while event held low
// - full_speed_on_event applies only to a running fan
// - full_speed_on_event bit clear leaves fans unchanged
// - timer counts only while event asserted
// - timer saturates at full scale
// - timer read returns value then clears
// - bit 0 first assertion, then 22.76 ms lsb
// - read during assertion restarts with bit 0
// - limit zero alerts on first assertion
// - mask bit suppresses alert, flag still sets
// - monitoring disabled after reset
// - status flag sticky until timer value no longer above limit and status read
// - alert held until status read with timer value no longer above limit
`timescale 1ns/1ps
`default_nettype none
module tetm_top
   import tetm_pkg::*;
#(
   parameter int LSB_CYCLES = TETM_TIMER_LSB_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [TETM_AW-1:0] paddr,
   input wire logic [TETM_DW-1:0] pwdata,
   output logic [TETM_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic thermal_event_n,
   input wire logic shared_pin_in,
   output logic shared_pin_out,
   output logic shared_pin_oe,
   output logic [1:0] shared_pin_function_select,
   output logic dedicated_pin_is_measurement,
   input wire tetm_fan_type [TETM_NUM_FANS-1:0] fan_state,
   output logic [TETM_NUM_FANS-1:0] fan_full_speed
);
   logic [7:0] mask_one_reg;
   logic [7:0] mask_two_reg;
   logic [7:0] config_three_reg;
   logic [7:0] timer_limit_reg;
   logic [7:0] config_four_reg;
   logic fan4_or_timer_flag_reg;
   logic fan4_or_timer_flag_next;
   tetm_bus_state_type bus_state_reg;
   logic [1:0] pins_sync;
   logic [7:0] timer_value;
   logic [7:0] read_byte;
   logic addr_hit;

   // ---------------- event input ----------------
   tetm_sync #(
      .WIDTH(2)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({shared_pin_in, thermal_event_n}),
      .sync_out(pins_sync)
   );

   wire event_enable = config_three_reg[TETM_CFG3_EVENT_EN];
   wire tetm_pin_func_type pin_func = tetm_pin_func_type'(config_four_reg[TETM_CFG4_FUNC_LO +: 2]);
   wire shared_is_event = event_enable && (pin_func == TETM_FUNC_EVENT);
   wire shared_is_alert = (pin_func == TETM_FUNC_ALERT);
   wire dedicated_active = event_enable && !pins_sync[0];
   wire shared_active = shared_is_event && !pins_sync[1];
   wire event_now = dedicated_active || shared_active;

   // ---------------- timer ----------------
   wire bus_done = psel && penable && pready;
   wire rd_done = bus_done && !pwrite && !pslverr;
   wire wr_done = bus_done && pwrite && !pslverr;
   wire timer_read = rd_done && (paddr == tetm_byte_addr(TETM_IDX_TIMER_VALUE));
   wire status_read = rd_done && (paddr == tetm_byte_addr(TETM_IDX_STATUS_TWO));

   tetm_timer #(
      .LSB_CYCLES(LSB_CYCLES)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .event_active(event_now),
      .clear(timer_read),
      .value(timer_value)
   );

   // ---------------- limit, flag, alert ----------------
   wire over_limit = (timer_value > timer_limit_reg);
   // set wins over the clear made by a status read
   always_comb begin
      fan4_or_timer_flag_next = fan4_or_timer_flag_reg;
      if (status_read && !over_limit)
         fan4_or_timer_flag_next = 1'b0;
      if (over_limit)
         fan4_or_timer_flag_next = 1'b1;
   end

   wire ded_unmasked = event_enable && !mask_one_reg[TETM_MASK1_DEDICATED];
   wire shr_unmasked = shared_is_event && !mask_two_reg[TETM_MASK2_SHARED];
   wire alert_next = fan4_or_timer_flag_next && (ded_unmasked || shr_unmasked);

   // ---------------- fan full_speed_on_event ----------------
   logic [TETM_NUM_FANS-1:0] fan_running;
   always_comb begin
      for (int i = 0; i < TETM_NUM_FANS; i++) begin
         fan_running[i] = fan_state[i].manual_mode ?
                          (fan_state[i].manual_duty != TETM_DUTY_OFF) :
                          fan_state[i].above_start_temp;
      end
   end
   wire full_speed_on_event_on = config_three_reg[TETM_CFG3_FULL_SPEED] && event_now;
   wire [TETM_NUM_FANS-1:0] full_speed_on_event_next = full_speed_on_event_on ? fan_running : '0;

   // ---------------- register decode ----------------
   always_comb begin
      addr_hit = 1'b1;
      read_byte = TETM_RESET_BYTE;
      case (paddr)
         tetm_byte_addr(TETM_IDX_STATUS_TWO):
            read_byte[TETM_STAT2_FAN4_TIMER] = fan4_or_timer_flag_reg;
         tetm_byte_addr(TETM_IDX_MASK_ONE): read_byte = mask_one_reg;
         tetm_byte_addr(TETM_IDX_MASK_TWO): read_byte = mask_two_reg;
         tetm_byte_addr(TETM_IDX_CONFIG_THREE): read_byte = config_three_reg;
         tetm_byte_addr(TETM_IDX_TIMER_VALUE): read_byte = timer_value;
         tetm_byte_addr(TETM_IDX_TIMER_LIMIT): read_byte = timer_limit_reg;
         tetm_byte_addr(TETM_IDX_CONFIG_FOUR): read_byte = config_four_reg;
         default: addr_hit = 1'b0;
      endcase
   end

   // status and timer are read only; writes there are accepted and dropped
   wire wr_mask_one = wr_done && (paddr == tetm_byte_addr(TETM_IDX_MASK_ONE));
   wire wr_mask_two = wr_done && (paddr == tetm_byte_addr(TETM_IDX_MASK_TWO));
   wire wr_config_three = wr_done && (paddr == tetm_byte_addr(TETM_IDX_CONFIG_THREE));
   wire wr_limit = wr_done && (paddr == tetm_byte_addr(TETM_IDX_TIMER_LIMIT));
   wire wr_config_four = wr_done && (paddr == tetm_byte_addr(TETM_IDX_CONFIG_FOUR));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_one_reg <= TETM_RESET_BYTE;
         mask_two_reg <= TETM_RESET_BYTE;
         config_three_reg <= TETM_RESET_BYTE;
         timer_limit_reg <= TETM_RESET_BYTE;
         config_four_reg <= TETM_RESET_BYTE;
      end else begin
         if (wr_mask_one)
            mask_one_reg <= pwdata[7:0];
         if (wr_mask_two)
            mask_two_reg <= pwdata[7:0];
         if (wr_config_three)
            config_three_reg <= pwdata[7:0];
         if (wr_limit)
            timer_limit_reg <= pwdata[7:0];
         if (wr_config_four)
            config_four_reg <= pwdata[7:0];
      end
   end

   // ---------------- apb answer ----------------
   // read data is caught in the setup cycle so every output comes from a flop;
   // one access cycle, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_state_reg <= TETM_BUS_IDLE;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         case (bus_state_reg)
            TETM_BUS_IDLE: begin
               if (psel && !penable) begin
                  bus_state_reg <= TETM_BUS_ANSWER;
                  prdata <= {24'h000000, read_byte};
                  pready <= 1'b1;
                  pslverr <= !addr_hit;
               end
            end
            TETM_BUS_ANSWER: begin
               bus_state_reg <= TETM_BUS_IDLE;
               pready <= 1'b0;
               pslverr <= 1'b0;
            end
            default: begin
               bus_state_reg <= TETM_BUS_IDLE;
               pready <= 1'b0;
               pslverr <= 1'b0;
            end
         endcase
      end
   end

   // ---------------- status and pin outputs ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fan4_or_timer_flag_reg <= 1'b0;
         shared_pin_out <= 1'b0;
         shared_pin_oe <= 1'b0;
         shared_pin_function_select <= 2'h0;
         dedicated_pin_is_measurement <= 1'b1;
         fan_full_speed <= '0;
      end else begin
         fan4_or_timer_flag_reg <= fan4_or_timer_flag_next;
         // open drain alert: pulled low only while the shared pin carries it
         shared_pin_out <= 1'b0;
         shared_pin_oe <= shared_is_alert && alert_next;
         shared_pin_function_select <= config_four_reg[TETM_CFG4_FUNC_LO +: 2];
         dedicated_pin_is_measurement <= !event_enable;
         fan_full_speed <= full_speed_on_event_next;
      end
   end
endmodule // tetm_top
`default_nettype wire

// [tetm_top_asserts.sv]
// port-level assertions for the thermal event timer monitor
`timescale 1ns/1ps
`default_nettype none
module tetm_top_asserts
   import tetm_pkg::*;
#(
   parameter int LSB_CYCLES = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [TETM_AW-1:0] paddr,
   input wire logic [TETM_DW-1:0] pwdata,
   input wire logic [TETM_DW-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic thermal_event_n,
   input wire logic shared_pin_in,
   input wire logic shared_pin_out,
   input wire logic shared_pin_oe,
   input wire logic [1:0] shared_pin_function_select,
   input wire logic dedicated_pin_is_measurement,
   input wire tetm_fan_type [TETM_NUM_FANS-1:0] fan_state,
   input wire logic [TETM_NUM_FANS-1:0] fan_full_speed
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic done_w = psel && penable && pready;
   wire logic ev_any = !thermal_event_n || !shared_pin_in;
   wire logic run1 = fan_state[1].manual_mode ? (fan_state[1].manual_duty != TETM_DUTY_OFF)
      : fan_state[1].above_start_temp;
   wire logic cfg3_w = done_w && pwrite && paddr == tetm_byte_addr(TETM_IDX_CONFIG_THREE);
   logic touched_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) touched_reg <= 1'b0;
      else if (cfg3_w) touched_reg <= 1'b1;
   end
   sequence s_wr(a);
      done_w && pwrite && paddr == a;
   endsequence
   a_func_follows_cfg: assert property (
      s_wr(tetm_byte_addr(TETM_IDX_CONFIG_FOUR)) |->
      ##2 shared_pin_function_select == $past(pwdata[1:0], 2))
      else $error("shared function wrong");
   a_measure_mode_sel: assert property (
      s_wr(tetm_byte_addr(TETM_IDX_CONFIG_THREE)) |->
      ##2 dedicated_pin_is_measurement == !$past(pwdata[1], 2))
      else $error("measurement mode wrong");
   a_full_speed_on_event_needs_event: assert property (
      (thermal_event_n && shared_pin_in) [*5] |-> fan_full_speed == '0)
      else $error("full_speed_on_event without event");
   a_idle_fan_stays: assert property (
      (!run1) [*5] |-> !fan_full_speed[1])
      else $error("stopped fan boosted");
   a_reset_disabled: assert property (
      !touched_reg |-> dedicated_pin_is_measurement && fan_full_speed == '0)
      else $error("monitoring on after reset");
   a_full_speed_on_event_synced: assert property (
      $rose(fan_full_speed[0]) |-> $past(ev_any, 3))
      else $error("full_speed_on_event not synchronised");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == '0)
      else $error("upper read bits set");
endmodule // tetm_top_asserts
bind tetm_top tetm_top_asserts #(.LSB_CYCLES(LSB_CYCLES)) chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .thermal_event_n(thermal_event_n),
   .shared_pin_in(shared_pin_in), .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe),
   .shared_pin_function_select(shared_pin_function_select),
   .dedicated_pin_is_measurement(dedicated_pin_is_measurement), .fan_state(fan_state),
   .fan_full_speed(fan_full_speed));
`default_nettype wire

// [tetm_event_src.sv]
// event source model driving the dedicated and shared thermal event pins
`timescale 1ns/1ps
`default_nettype none
module tetm_event_src (
   input wire logic hold_ded,
   input wire logic hold_sh,
   input wire logic alert_oe,
   output wire logic thermal_event_n,
   output wire logic shared_pin_in
);
   // open drain with pull-ups; the skew keeps pin edges unrelated to the clock
   assign #13 thermal_event_n = !hold_ded;
   assign #13 shared_pin_in = !(hold_sh || alert_oe);
endmodule // tetm_event_src
`default_nettype wire

// [thermal_event_timer_monitor_bench.sv]
// self-checking bench for the thermal event timer monitor
`timescale 1ns/1ps
`default_nettype none
module thermal_event_timer_monitor_bench import tetm_pkg::*;;
   localparam logic [7:0] REGS [7] = '{8'h42, 8'h74, 8'h75, 8'h78, 8'h79, 8'h7a, 8'h7d};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [TETM_AW-1:0] paddr = '0;
   logic [TETM_DW-1:0] pwdata = '0;
   wire logic [TETM_DW-1:0] prdata;
   wire logic pready, pslverr, ev_n, sh_in, sh_out, sh_oe, meas;
   wire logic [1:0] func;
   wire logic [2:0] ffs;
   tetm_fan_type [TETM_NUM_FANS-1:0] fans = '0;
   logic hold_d = 1'b0, hold_s = 1'b0;
   logic [16:0] notes[$];
   logic [16:0] nt;
   int bad_count = 0, cmp_count = 0;
   logic [31:0] seed;
   initial begin
      forever #20 pclk = ~pclk;
   end
   tetm_top #(.LSB_CYCLES(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .thermal_event_n(ev_n), .shared_pin_in(sh_in),
      .shared_pin_out(sh_out), .shared_pin_oe(sh_oe), .shared_pin_function_select(func),
      .dedicated_pin_is_measurement(meas), .fan_state(fans), .fan_full_speed(ffs));
   tetm_event_src src_u (.hold_ded(hold_d), .hold_sh(hold_s), .alert_oe(sh_oe),
      .thermal_event_n(ev_n), .shared_pin_in(sh_in));
   task automatic give_verdict;
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   // note holds error flag, compare mask and expected byte
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
      input logic [16:0] note);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'($urandom()), d};
      notes.push_back(note);
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 20) begin
            bad_count++;
            give_verdict();
         end
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, 17'h0);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
      apb(1'b0, idx, 8'h00, {1'b0, m, e});
   endtask
   task automatic ev(input int n);
      hold_d <= 1'b1;
      repeat (n) @(posedge pclk);
      hold_d <= 1'b0;
      repeat (5) @(posedge pclk);
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
         nt = notes.pop_front();
         check("read", {nt[16], nt[7:0]}, {pslverr, prdata[7:0] & nt[15:8]});
      end
   end
   initial begin
      seed = $urandom(32'h00b5);
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 7; i++) rd(REGS[i], 8'hff, 8'h00);
      check("measure", 9'(1), 9'(meas));
      apb(1'b0, 8'h01, 8'h00, {1'b1, 16'h0});
      wr(8'h79, 8'h55);
      rd(8'h79, 8'hff, 8'h00);
      wr(8'h7d, 8'h01);
      hold_s <= 1'b1;
      repeat (20) @(posedge pclk);
      hold_s <= 1'b0;
      rd(8'h79, 8'hff, 8'h00);
      for (int f = 0; f < 4; f++) begin
         wr(8'h7d, 8'(f));
         repeat (3) @(posedge pclk);
         check("function", 9'(f), 9'(func));
      end
      wr(8'h78, 8'h02);
      wr(8'h7d, 8'h01);
      check("measure", 9'(0), 9'(meas));
      hold_s <= 1'b1;
      repeat (20) @(posedge pclk);
      hold_s <= 1'b0;
      repeat (5) @(posedge pclk);
      rd(8'h79, 8'hff, 8'h02);
      wr(8'h7d, 8'h00);
      ev(4);
      rd(8'h79, 8'hff, 8'h01);
      ev(22);
      ev(22);
      rd(8'h79, 8'hff, 8'h05);
      rd(8'h79, 8'hff, 8'h00);
      // software polls the timer once per equal monitoring interval
      for (int k = 0; k < 2; k++) begin
         ev(20);
         rd(8'h79, 8'hff, 8'h02);
      end
      ev(2200);
      rd(8'h79, 8'hff, 8'hff);
      wr(8'h7a, 8'h00);
      hold_d <= 1'b1;
      repeat (20) @(posedge pclk);
      rd(8'h79, 8'h00, 8'h00);
      rd(8'h79, 8'hff, 8'h01);
      rd(8'h42, 8'h20, 8'h20);
      hold_d <= 1'b0;
      repeat (5) @(posedge pclk);
      rd(8'h79, 8'h00, 8'h00);
      rd(8'h42, 8'h20, 8'h20);
      rd(8'h42, 8'h20, 8'h00);
      wr(8'h7d, 8'h02);
      wr(8'h7a, 8'h02);
      ev(22);
      check("alert", 9'(0), 9'(sh_oe));
      ev(10);
      check("alert", 9'(1), 9'(sh_oe));
      check("pin out", 9'(0), 9'(sh_out));
      rd(8'h42, 8'h20, 8'h20);
      check("alert", 9'(1), 9'(sh_oe));
      rd(8'h79, 8'h00, 8'h00);
      rd(8'h42, 8'h20, 8'h20);
      rd(8'h42, 8'h20, 8'h00);
      repeat (2) @(posedge pclk);
      check("alert", 9'(0), 9'(sh_oe));
      wr(8'h74, 8'h01);
      ev(32);
      check("alert", 9'(0), 9'(sh_oe));
      rd(8'h42, 8'h20, 8'h20);
      rd(8'h79, 8'h00, 8'h00);
      rd(8'h42, 8'h20, 8'h20);
      wr(8'h74, 8'h00);
      fans[0] <= '{1'b1, 8'($urandom()) | 8'h01, 1'b0};
      fans[1] <= '{1'b1, 8'h00, 1'b1};
      fans[2] <= '{1'b0, 8'($urandom()), 1'($urandom())};
      wr(8'h78, 8'h06);
      hold_d <= 1'b1;
      repeat (8) @(posedge pclk);
      check("full_speed_on_event", 9'({fans[2].above_start_temp, 2'b01}), 9'(ffs));
      hold_d <= 1'b0;
      repeat (6) @(posedge pclk);
      check("full_speed_on_event", 9'(0), 9'(ffs));
      wr(8'h78, 8'h02);
      hold_d <= 1'b1;
      repeat (8) @(posedge pclk);
      check("full_speed_on_event", 9'(0), 9'(ffs));
      hold_d <= 1'b0;
      repeat (4) @(posedge pclk);
      give_verdict();
   end
endmodule // thermal_event_timer_monitor_bench
`default_nettype wire
